// ### src/vic_pkg.sv
// Purpose: shared constants and types of the vectored interrupt controller
// Assumes: 32-bit APB register bus, one clock
// Notes:   vector count and source counts are fixed
package vic_pkg;
    localparam int NUM_VEC   = 8;
    localparam int VEC_W     = 3;
    localparam int DMA_LINES = 8;   // two lines per channel, four channels
    localparam int DSEL_W    = 3;
    localparam int PRIO_W    = 3;
    localparam int ADDR_W    = 16;

    // ------------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_ENABLE  = 8'h00;
    localparam logic [7:0] OFS_SETPEND = 8'h04;
    localparam logic [7:0] OFS_CLRPEND = 8'h08;
    localparam logic [7:0] OFS_SRCSEL  = 8'h0C;
    localparam logic [7:0] OFS_DMASEL  = 8'h10;
    localparam logic [7:0] OFS_PRIO    = 8'h14;
    localparam logic [7:0] OFS_VECBASE = 8'h18;
    localparam logic [7:0] OFS_STATE   = 8'h1C;
    localparam logic [7:0] OFS_EVSTAT  = 8'h20;
    localparam logic [7:0] OFS_EVMASK  = 8'h24;

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int STATE_POSTED_FLAG_LSB = 8;
    localparam int STATE_VEC_LSB  = 16;
    localparam int STATE_ACT_BIT  = 19;
    localparam logic [NUM_VEC-1:0] RST_ENABLE = 8'h00;
    localparam logic [ADDR_W-1:0]  RST_VECBASE = 16'h0000;
    localparam logic [NUM_VEC-1:0] RST_EVMASK = 8'h00;

    // ------------------------------------------------------------------
    // timing counts, in pclk cycles
    // ------------------------------------------------------------------
    localparam logic [1:0] EVAL_CLKS = 2'h3;

    typedef enum logic [1:0] {
        SRC_FIXED = 2'b00,
        SRC_DMA   = 2'b01,
        SRC_ARRAY = 2'b10
    } src_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_EVAL = 3'b001,
        ST_REQ  = 3'b010,
        ST_POSTED_FLAG = 3'b011,
        ST_RUN  = 3'b100
    } vic_state_e;

    typedef struct packed {
        logic              irq;
        logic [VEC_W-1:0]  num;
        logic [ADDR_W-1:0] addr;
    } core_req_s;
endpackage

// ### src/vic_top.sv
// Purpose: vectored interrupt controller feeding a processor core
// Assumes: sources may be asynchronous; core gives acknowledge and return
// Notes:   lower priority value is more urgent; one handler at a time
module vic_top
    import vic_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata_ff,
    output logic                      pready_ff,
    output logic                      pslverr_ff,
    input  wire logic [NUM_VEC-1:0]   fixed_src,
    input  wire logic [DMA_LINES-1:0] dma_src,
    input  wire logic [NUM_VEC-1:0]   array_src,
    input  wire logic                 core_acknowledge,
    input  wire logic                 return_from_handler,
    output core_req_s                 core_req_ff,
    output logic                      handler_complete_ff,
    output logic                      irq_out_ff
);
    // ------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------
    // returns {found, vector}; scanning downward with <= lets the lower
    // vector number take an equal priority
    function automatic logic [VEC_W:0] pick(
        input logic [NUM_VEC-1:0]        req,
        input logic [NUM_VEC*PRIO_W-1:0] pr);
        logic [VEC_W:0]  res;
        logic [PRIO_W-1:0] best;
        res  = '0;
        best = '1;
        for (int i = NUM_VEC - 1; i >= 0; i--) begin
            if (req[i] && (!res[VEC_W] || pr[i*PRIO_W +: PRIO_W] <= best))
            begin
                res  = {1'b1, VEC_W'(i)};
                best = pr[i*PRIO_W +: PRIO_W];
            end
        end
        return res;
    endfunction

    function automatic logic [ADDR_W-1:0] handler_addr(
        input logic [ADDR_W-1:0] base, input logic [VEC_W-1:0] v);
        return base + ADDR_W'({v, 2'b00});
    endfunction

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [NUM_VEC-1:0]        enable_ff;
    logic [2*NUM_VEC-1:0]      srcsel_ff;
    logic [DSEL_W*NUM_VEC-1:0] dmasel_ff;
    logic [PRIO_W*NUM_VEC-1:0] prio_ff;
    logic [ADDR_W-1:0]         vecbase_ff;
    logic [NUM_VEC-1:0]        evstat_ff;
    logic [NUM_VEC-1:0]        evmask_ff;
    logic [NUM_VEC-1:0]        pending_flag_ff;
    logic [NUM_VEC-1:0]        posted_flag_ff;
    logic [NUM_VEC-1:0]        sync1_ff, sync2_ff, prev_ff;
    logic [NUM_VEC-1:0]        line;
    vic_state_e                state_ff;
    logic [1:0]                cnt_ff;
    logic [VEC_W-1:0]          win_ff;
    logic                      active_ff;
    logic [VEC_W-1:0]          active_vec_ff;
    logic                      prev_active_ff;
    logic [VEC_W-1:0]          prev_vec_ff;
    logic                      clr_posted_flag_ff;

    wire logic apb_setup = psel && penable && !pready_ff;
    wire logic apb_done  = psel && penable && pready_ff;
    wire logic wr_done   = apb_done && pwrite;
    wire logic rd_done   = apb_done && !pwrite;
    wire logic [NUM_VEC-1:0] sw_set =
        (wr_done && paddr == OFS_SETPEND) ? pwdata[NUM_VEC-1:0] : '0;
    wire logic [NUM_VEC-1:0] sw_clr =
        (wr_done && paddr == OFS_CLRPEND) ? pwdata[NUM_VEC-1:0] : '0;
    wire logic [NUM_VEC-1:0] cand = posted_flag_ff & enable_ff;
    wire logic [VEC_W:0]     sel  = pick(cand, prio_ff);

    // ------------------------------------------------------------------
    // source selection
    // ------------------------------------------------------------------
    always_comb begin
        for (int v = 0; v < NUM_VEC; v++) begin
            case (src_e'(srcsel_ff[2*v +: 2]))
                SRC_FIXED: line[v] = fixed_src[v];
                SRC_DMA:   line[v] =
                    dma_src[dmasel_ff[DSEL_W*v +: DSEL_W]];
                SRC_ARRAY: line[v] = array_src[v];
                default:   line[v] = 1'b0;
            endcase
        end
    end

    // inputs may be asynchronous: two flops, then edge detect on the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            prev_ff  <= '0;
        end else begin
            sync1_ff <= line;
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    // ------------------------------------------------------------------
    // pending and posted flags
    // ------------------------------------------------------------------
    wire logic [NUM_VEC-1:0] trig = sync2_ff & ~prev_ff;
    wire logic [NUM_VEC-1:0] ack_clr =
        (state_ff == ST_REQ && core_acknowledge) ?
        NUM_VEC'(1) << win_ff : '0;

    // a new trigger or software set wins over any clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            pending_flag_ff <= '0;
        else
            pending_flag_ff <= (pending_flag_ff & ~sw_clr & ~ack_clr)
                               | trig
                               | sw_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            clr_posted_flag_ff <= 1'b0;
        else
            clr_posted_flag_ff <= (ack_clr != '0);
    end

    wire logic [NUM_VEC-1:0] posted_flag_clr =
        sw_clr | (clr_posted_flag_ff ? NUM_VEC'(1) << active_vec_ff : '0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            posted_flag_ff <= '0;
        else
            posted_flag_ff <= (posted_flag_ff & ~posted_flag_clr)
                              | (pending_flag_ff & ~sw_clr &
                                 ~(clr_posted_flag_ff ? '0 : ack_clr));
    end

    // ------------------------------------------------------------------
    // request sequence
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= ST_IDLE;
            cnt_ff   <= '0;
            win_ff   <= '0;
        end else begin
            case (state_ff)
                ST_IDLE: if (sel[VEC_W] && !active_ff) begin
                    state_ff <= ST_EVAL;
                    cnt_ff   <= EVAL_CLKS - 2'h1;
                end
                ST_EVAL: begin
                    cnt_ff <= cnt_ff - 2'h1;
                    win_ff <= sel[VEC_W-1:0];
                    if (!sel[VEC_W])
                        state_ff <= ST_IDLE;
                    else if (cnt_ff == 2'h1)
                        state_ff <= ST_REQ;
                end
                ST_REQ: if (core_acknowledge)
                    state_ff <= ST_POSTED_FLAG;
                else if (!cand[win_ff])
                    state_ff <= ST_IDLE;
                ST_POSTED_FLAG: state_ff <= ST_RUN;
                ST_RUN: if (return_from_handler && !core_acknowledge)
                    state_ff <= ST_IDLE;
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // request held until the core acknowledges at an instruction boundary, or dropped once the winner is no longer in cand
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_req_ff <= '0;
        end else begin
            core_req_ff.irq  <= state_ff == ST_REQ ? !core_acknowledge
                                && cand[win_ff]
                                : state_ff == ST_EVAL && cnt_ff == 2'h1
                                && sel[VEC_W];
            core_req_ff.num  <= state_ff == ST_EVAL ?
                                sel[VEC_W-1:0] : core_req_ff.num;
            core_req_ff.addr <= state_ff == ST_EVAL ?
                                handler_addr(vecbase_ff,
                                sel[VEC_W-1:0]) : core_req_ff.addr;
        end
    end

    // ------------------------------------------------------------------
    // active status and completion
    // ------------------------------------------------------------------
    wire logic finish = state_ff == ST_RUN && return_from_handler
                        && !core_acknowledge;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_ff      <= 1'b0;
            active_vec_ff  <= '0;
            prev_active_ff <= 1'b0;
            prev_vec_ff    <= '0;
        end else if (state_ff == ST_REQ && core_acknowledge) begin
            prev_active_ff <= active_ff;
            prev_vec_ff    <= active_vec_ff;
            active_ff      <= 1'b1;
            active_vec_ff  <= win_ff;
        end else if (finish) begin
            active_ff     <= prev_active_ff;
            active_vec_ff <= prev_vec_ff;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            handler_complete_ff <= 1'b0;
        else
            handler_complete_ff <= finish;
    end

    // completion events are sticky; a read clears, a new event wins
    wire logic [NUM_VEC-1:0] ev_set = finish ? NUM_VEC'(1) << active_vec_ff
                                             : '0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            evstat_ff <= '0;
        else
            evstat_ff <= ((rd_done && paddr == OFS_EVSTAT) ? '0 : evstat_ff)
                         | ev_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            irq_out_ff <= 1'b0;
        else
            irq_out_ff <= |(evstat_ff & evmask_ff);
    end

    // ------------------------------------------------------------------
    // APB slave: one wait state, then pready
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            pready_ff <= 1'b0;
        else
            pready_ff <= apb_setup;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_ff  <= RST_ENABLE;
            srcsel_ff  <= '0;
            dmasel_ff  <= '0;
            prio_ff    <= '0;
            vecbase_ff <= RST_VECBASE;
            evmask_ff  <= RST_EVMASK;
        end else if (wr_done) begin
            case (paddr)
                OFS_ENABLE:  enable_ff  <= pwdata[NUM_VEC-1:0];
                OFS_SRCSEL:  srcsel_ff  <= pwdata[2*NUM_VEC-1:0];
                OFS_DMASEL:  dmasel_ff  <= pwdata[DSEL_W*NUM_VEC-1:0];
                OFS_PRIO:    prio_ff    <= pwdata[PRIO_W*NUM_VEC-1:0];
                OFS_VECBASE: vecbase_ff <= pwdata[ADDR_W-1:0];
                OFS_EVMASK:  evmask_ff  <= pwdata[NUM_VEC-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff  <= '0;
            pslverr_ff <= 1'b0;
        end else if (apb_setup) begin
            pslverr_ff <= 1'b0;
            prdata_ff  <= '0;
            case (paddr)
                OFS_ENABLE:  prdata_ff <= 32'(enable_ff);
                OFS_SETPEND,
                OFS_CLRPEND: prdata_ff <= 32'(pending_flag_ff);
                OFS_SRCSEL:  prdata_ff <= 32'(srcsel_ff);
                OFS_DMASEL:  prdata_ff <= 32'(dmasel_ff);
                OFS_PRIO:    prdata_ff <= 32'(prio_ff);
                OFS_VECBASE: prdata_ff <= 32'(vecbase_ff);
                OFS_STATE:   prdata_ff <= 32'({active_ff, active_vec_ff,
                                           posted_flag_ff, pending_flag_ff});
                OFS_EVSTAT:  prdata_ff <= 32'(evstat_ff);
                OFS_EVMASK:  prdata_ff <= 32'(evmask_ff);
                default:     pslverr_ff <= 1'b1;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    sequence ack_seen;
        state_ff == ST_REQ && core_acknowledge;
    endsequence

    pending_flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        trig != '0 |=> (pending_flag_ff & $past(trig)) == $past(trig))
        else $error("trigger did not set pending");

    posted_flag_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(pending_flag_ff[0]) && sw_clr == '0 && ack_clr == '0
        |=> posted_flag_ff[0])
        else $error("posted not set after pending");

    eval_len_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_ff == ST_IDLE ##1 state_ff == ST_EVAL
        |-> ##2 (state_ff == ST_REQ || state_ff == ST_IDLE))
        else $error("evaluation not three clocks");

    req_num_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(core_req_ff.irq) |-> core_req_ff.num == win_ff
        && core_req_ff.addr == handler_addr(vecbase_ff, win_ff))
        else $error("request number or address wrong");

    tie_a: assert property (@(posedge pclk) disable iff (!presetn)
        cand[4] && cand[5]
        && prio_ff[4*PRIO_W +: PRIO_W] == prio_ff[5*PRIO_W +: PRIO_W]
        |-> sel[VEC_W-1:0] != VEC_W'(5))
        else $error("higher vector won a tie");

    ack_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        ack_seen and (trig[win_ff] == 1'b0) and (sw_set[win_ff] == 1'b0)
        |=> !pending_flag_ff[$past(win_ff)] && clr_posted_flag_ff)
        else $error("acknowledge did not clear pending");

    restore_a: assert property (@(posedge pclk) disable iff (!presetn)
        finish |=> active_ff == $past(prev_active_ff)
                   && handler_complete_ff)
        else $error("active status not restored");

    sw_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        sw_set != '0 |=> (pending_flag_ff & $past(sw_set))
                         == $past(sw_set))
        else $error("software raise lost");

    sw_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
        sw_clr[NUM_VEC-1] && !sw_set[NUM_VEC-1] && !trig[NUM_VEC-1]
        |=> !pending_flag_ff[NUM_VEC-1])
        else $error("software clear ignored");
endmodule // vic_top

// ### tb/core_model.sv
// Purpose: behavioural processor core answering interrupt requests
// Assumes: one handler at a time, acknowledge level held high
// Notes:   ack_delay stretches the answer to mimic a busy core
module core_model
    import vic_pkg::*;
#(
    parameter int ACK_CYC = 7,
    parameter int RUN_CYC = 4
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire core_req_s     core_req,
    input  wire logic [7:0]    ack_delay,
    output logic               core_acknowledge,
    output logic               return_from_handler,
    output logic [VEC_W-1:0]   got_vec,
    output logic [ADDR_W-1:0]  got_addr,
    output int                 served_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    int n;

    // --------------------------------------------------------------
    // request service loop
    // --------------------------------------------------------------
    // one process owns every output, so nothing has two drivers;
    // a withdrawn request is simply abandoned, as a real core would
    initial begin
        core_acknowledge = 1'b0;
        return_from_handler = 1'b0;
        got_vec = '0;
        got_addr = '0;
        served_cnt = 0;
        forever begin
            @(posedge pclk);
            if (presetn === 1'b1 && core_req.irq === 1'b1) begin
                n = 0;
                while (n < ack_delay && core_req.irq === 1'b1) begin
                    @(posedge pclk);
                    n++;
                end
                if (core_req.irq === 1'b1) begin
                    core_acknowledge <= 1'b1;
                    got_vec <= core_req.num;
                    got_addr <= core_req.addr;
                    repeat (ACK_CYC) @(posedge pclk);
                    core_acknowledge <= 1'b0;
                    repeat (RUN_CYC) @(posedge pclk);
                    return_from_handler <= 1'b1;
                    @(posedge pclk);
                    return_from_handler <= 1'b0;
                    served_cnt <= served_cnt + 1;
                end
            end
        end
    end
endmodule // core_model

// ### tb/vectored_interrupt_controller_test.sv
// Purpose: self-checking bench for the vectored interrupt controller
// Assumes: APB master tasks, core model on the request side
// Notes:   waits are bounded; a hang counts as a mismatch
module vectored_interrupt_controller_test;
    timeunit 1ns;
    timeprecision 1ps;
    import vic_pkg::*;
    logic                 pclk, presetn, psel, penable, pwrite, er;
    logic [7:0]           paddr, ack_delay;
    logic [31:0]          pwdata, prdata_ff, rd;
    logic                 pready_ff, pslverr_ff, core_acknowledge;
    logic                 return_from_handler, handler_complete_ff;
    logic                 irq_out_ff;
    logic [NUM_VEC-1:0]   fixed_src, array_src;
    logic [DMA_LINES-1:0] dma_src;
    core_req_s            core_req_ff;
    logic [VEC_W-1:0]     got_vec;
    logic [ADDR_W-1:0]    got_addr;
    int                   served_cnt, err_total, tests_run, done_cnt, n;

    vic_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
        .pslverr_ff(pslverr_ff), .fixed_src(fixed_src),
        .dma_src(dma_src), .array_src(array_src),
        .core_acknowledge(core_acknowledge),
        .return_from_handler(return_from_handler),
        .core_req_ff(core_req_ff),
        .handler_complete_ff(handler_complete_ff),
        .irq_out_ff(irq_out_ff));
    core_model #(.ACK_CYC(7), .RUN_CYC(4)) partner (.pclk(pclk),
        .presetn(presetn), .core_req(core_req_ff), .ack_delay(ack_delay),
        .core_acknowledge(core_acknowledge),
        .return_from_handler(return_from_handler), .got_vec(got_vec),
        .got_addr(got_addr), .served_cnt(served_cnt));

    always #2.5 pclk = ~pclk;
    always @(posedge pclk) if (handler_complete_ff === 1'b1) done_cnt++;

    // --------------------------------------------------------------
    // tasks
    // --------------------------------------------------------------
    task automatic report_and_stop();
        if (err_total == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic hang(input string nm);
        chk(nm, 32'h1, 32'h0);
        report_and_stop();
    endtask
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready_ff !== 1'b1 && k < 20);
        if (pready_ff !== 1'b1) hang("pready wait");
        rd = prdata_ff;
        er = pslverr_ff;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e, input string nm);
        xfer(a, 1'b0, 32'h0);
        chk(nm, e, rd & m);
    endtask
    // counts settled cycles until the request line reaches lvl
    task automatic wait_irq(input logic lvl, output int c);
        c = 0;
        do begin
            @(posedge pclk);
            #1;
            c++;
        end while (core_req_ff.irq !== lvl && c < 80);
        if (core_req_ff.irq !== lvl) hang("request wait");
    endtask
    task automatic chk_srv(input int idx, input logic [VEC_W-1:0] v);
        int k;
        k = 0;
        while (served_cnt < idx && k < 300) begin
            @(posedge pclk);
            k++;
        end
        if (served_cnt < idx) hang("service wait");
        chk("vector", 32'(v), 32'(got_vec));
        chk("handler addr", 32'h1200 + 32'(v) * 4, 32'(got_addr));
    endtask

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {fixed_src, dma_src, array_src, ack_delay} = '0;
        {err_total, tests_run, done_cnt} = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rdc(OFS_ENABLE, 32'hFF, 32'(RST_ENABLE), "enable reset");
        rdc(OFS_VECBASE, 32'hFFFF, 32'(RST_VECBASE), "vecbase reset");
        rdc(OFS_EVMASK, 32'hFF, 32'(RST_EVMASK), "evmask reset");
        rdc(8'h30, 32'hFFFFFFFF, 32'h0, "unmapped data");
        chk("unmapped error", 32'h1, 32'(er));
        wr(OFS_VECBASE, 32'h1200);
        wr(OFS_PRIO, 32'h0);
        wr(OFS_SRCSEL, 32'hFFE4);
        wr(OFS_DMASEL, 32'h28);
        wr(OFS_ENABLE, 32'hFF);
        fixed_src[0] <= 1'b1;
        wait_irq(1'b1, n);
        // two sync flops, pending, posted, then three evaluation clocks
        chk("trigger to request", 32'd7, 32'(n));
        chk_srv(1, 3'd0);
        rdc(OFS_STATE, 32'h0008FFFF, 32'h0, "state after");
        dma_src[5] <= 1'b1;
        chk_srv(2, 3'd1);
        array_src[2] <= 1'b1;
        chk_srv(3, 3'd2);
        fixed_src[1] <= 1'b1;
        dma_src[4] <= 1'b1;
        repeat (30) @(posedge pclk);
        chk("unselected line", 32'd3, 32'(served_cnt));
        wr(OFS_PRIO, 32'h000C9400);
        wr(OFS_SETPEND, 32'h78);
        chk_srv(4, 3'd4);
        chk_srv(5, 3'd5);
        chk_srv(6, 3'd3);
        chk_srv(7, 3'd6);
        chk("masked event", 32'h0, 32'(irq_out_ff));
        ack_delay <= 8'd60;
        wr(OFS_SETPEND, 32'h80);
        wait_irq(1'b1, n);
        repeat (5) @(posedge pclk);
        chk("request held", 32'h1, 32'(core_req_ff.irq));
        wr(OFS_CLRPEND, 32'h80);
        wait_irq(1'b0, n);
        rdc(OFS_STATE, 32'hFFFF, 32'h0, "state cleared");
        repeat (70) @(posedge pclk);
        chk("withdrawn", 32'd7, 32'(served_cnt));
        ack_delay <= 8'd0;
        chk("completions", 32'd7, 32'(done_cnt));
        wr(OFS_EVMASK, 32'h80);
        repeat (3) @(posedge pclk);
        chk("other mask", 32'h0, 32'(irq_out_ff));
        wr(OFS_EVMASK, 32'h01);
        repeat (3) @(posedge pclk);
        chk("event irq", 32'h1, 32'(irq_out_ff));
        rdc(OFS_EVSTAT, 32'hFF, 32'h7F, "evstat");
        repeat (3) @(posedge pclk);
        chk("event cleared", 32'h0, 32'(irq_out_ff));
        rdc(OFS_EVSTAT, 32'hFF, 32'h0, "evstat clear");
        report_and_stop();
    end
endmodule // vectored_interrupt_controller_test
